// ---- verilog/analogue_node_cfg.sv ----
// analogue node configuration and reset control register bank
// assumes requests arrive on ref_clk; reset and brown-out pins are async
`timescale 1ns/1ps
module analogue_node_cfg #(
   parameter logic [7:0] CHIP_ID  = 8'h5a, // arbitrary value
   parameter logic [7:0] REV_ID   = 8'h11, // arbitrary value
   parameter logic [7:0] VER_ID   = 8'h22, // arbitrary value
   parameter int SYS_RST_CYCLES   = anode_pkg::SYS_RST_COUNT,
   parameter int TILE_RST_CYCLES  = anode_pkg::TILE_RST_COUNT
) (
   input  wire logic           ref_clk,      // reference clock
   input  wire logic           sys_rst,      // synchronous reset
   input  wire anode_pkg::cfg_req_t req,     // config request
   output anode_pkg::cfg_resp_t    resp,     // config answer
   input  wire logic           rst_pin_n,    // external reset pin
   input  wire logic           brown_out,    // supply brown-out pin
   input  wire logic           oscillator_select_pin, // boot strap
   input  wire logic           wdog_expire,  // watchdog expiry pulse
   input  wire logic           sleep_enter,  // sleep sequence pulse
   input  wire logic           clk_switch,   // clock source change
   output logic                sys_reset,    // system reset out
   output logic                tile_reset,   // tile reset out
   output logic                one_byte_hdr, // header mode
   output logic [15:0]         node_id,      // node identifier
   output logic [6:0]          clk_mhz,      // oscillator MHz
   output logic [31:0]         link_ctrl,    // link control word
   output logic [15:0]         wdog_timeout, // watchdog period
   output logic                wdog_enabled, // watchdog enable
   output logic [1:0]          mode_pin_o,   // mode pin drive
   output logic [1:0]          mode_pin_oe   // mode pin enable
);
   import anode_pkg::*;

   logic        pin_low_n;
   logic        brown_lvl;
   logic        osc_boot;
   logic        osc_done;
   logic [2:0]  settle;
   logic        cfg_lock;
   logic [31:0] wdog_off;
   logic        sys_busy;
   logic        tile_busy;
   logic        osc_lvl;

   // filtered asynchronous pins
   pin_sync3 #(.IDLE(1'b1)) u_rst_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (rst_pin_n),
      .level   (pin_low_n)
   );
   pin_sync3 #(.IDLE(1'b0)) u_bo_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (brown_out),
      .level   (brown_lvl)
   );
   pin_sync3 #(.IDLE(1'b0)) u_osc_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (oscillator_select_pin),
      .level   (osc_lvl)
   );

   // request decode
   wire take    = req.valid && !sys_busy;
   wire wr      = take && req.write;
   wire is_id   = req.num == REG_DEVICE_ID;
   wire is_ncfg = req.num == REG_NODE_CFG;
   wire is_nid  = req.num == REG_NODE_ID;
   wire is_rmc  = req.num == REG_RESET_MODE;
   wire is_clkf = req.num == REG_CLK_FREQ;
   wire is_link = req.num == REG_LINK_CTRL;
   wire is_wdt  = req.num == REG_WDOG_TIME;
   wire is_wdo  = req.num == REG_WDOG_OFF;
   wire mapped  = is_id | is_ncfg | is_nid | is_rmc | is_clkf
                | is_link | is_wdt | is_wdo;

   // write legality checks
   wire clkf_ok = req.data[6:0] >= CLKF_MIN && req.data[6:0] <= CLKF_MAX;
   wire wdt_ok  = req.data[31:16] == ~req.data[15:0];
   wire wr_bad  = !mapped || is_id || (is_clkf && !clkf_ok)
                || (is_wdt && !wdt_ok);

   // register strobes; lock blocks node cfg and link writes
   wire wr_ncfg = wr && is_ncfg && !cfg_lock;
   wire wr_link = wr && is_link && !cfg_lock;
   wire wr_nid  = wr && is_nid;
   wire wr_rmc  = wr && is_rmc;
   wire wr_clkf = wr && is_clkf && clkf_ok;
   wire wr_wdt  = wr && is_wdt && wdt_ok;
   wire wr_wdo  = wr && is_wdo;

   // software reset requests and response suppression
   wire sw_sys  = wr_rmc && req.data[RMC_SYS_BIT];
   wire sw_tile = wr_rmc && req.data[RMC_TILE_BIT];
   wire quiet   = sw_sys || sw_tile;

   // reset sources
   wire sys_go  = !pin_low_n || brown_lvl || wdog_expire
                || sw_sys;
   wire tile_go = sleep_enter || clk_switch || sw_tile;

   // system and tile reset spans
   reset_span_timer #(.CYCLES(SYS_RST_CYCLES)) u_sys_span (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .start   (sys_go),
      .busy    (sys_busy)
   );
   reset_span_timer #(.CYCLES(TILE_RST_CYCLES)) u_tile_span (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .start   (tile_go),
      .busy    (tile_busy)
   );

   // read words
   wire [31:0] id_word = {CHIP_ID, 7'h00, osc_boot, REV_ID, VER_ID};
   wire [31:0] ncfg_word = {cfg_lock, 30'h0, one_byte_hdr};
   wire [31:0] rmc_word = {7'h00, ~mode_pin_oe[0], 6'h00, mode_pin_o,
                           16'h0000}; // reset bits read 0
   wire [31:0] rd_word =
      is_id   ? id_word :
      is_ncfg ? ncfg_word :
      is_nid  ? {16'h0000, node_id} :
      is_rmc  ? rmc_word :
      is_clkf ? {25'h0, clk_mhz} :
      is_link ? link_ctrl :
      is_wdt  ? {16'h0000, wdog_timeout} :
      is_wdo  ? wdog_off :
      32'h0;

   // power-up oscillator strap, caught once after release
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         settle   <= 3'h0;
         osc_done <= 1'b0;
         osc_boot <= 1'b0;
      end else if (!osc_done) begin
         settle <= settle + 1'b1;
         if (settle == OSC_SETTLE) begin
            osc_done <= 1'b1;
            osc_boot <= osc_lvl;
         end
      end
   end

   // node configuration, identifier and link word
   always_ff @(posedge ref_clk) begin
      if (sys_rst || sys_go) begin
         cfg_lock     <= 1'b0;
         one_byte_hdr <= 1'b0;
         node_id      <= 16'h0000;
         link_ctrl    <= LINK_RESET;
      end else begin
         if (wr_ncfg) begin
            cfg_lock     <= req.data[NCFG_LOCK_BIT];
            one_byte_hdr <= req.data[NCFG_HDR_BIT];
         end
         if (wr_nid)
            node_id <= req.data[15:0];
         if (wr_link)
            link_ctrl <= req.data & LINK_RW;
      end
   end

   // mode pins, clock frequency and watchdog settings
   always_ff @(posedge ref_clk) begin
      if (sys_rst || sys_go) begin
         mode_pin_o   <= MODE_RESET;
         mode_pin_oe  <= 2'b00;
         clk_mhz      <= CLKF_RESET;
         wdog_timeout <= WDOG_RESET;
         wdog_off     <= WDOG_OFF_RESET;
         wdog_enabled <= 1'b0;
      end else begin
         if (wr_rmc) begin
            mode_pin_o  <= req.data[RMC_MODE_LSB +: 2];
            mode_pin_oe <= {2{~req.data[RMC_TRI_BIT]}};
         end
         if (wr_clkf)
            clk_mhz <= req.data[6:0];
         if (wr_wdt)
            wdog_timeout <= req.data[15:0];
         if (wr_wdo) begin
            wdog_off     <= req.data;
            wdog_enabled <= req.data == 32'h0;
         end
      end
   end

   // reset outputs; system reset also holds the tiles
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sys_reset  <= 1'b0;
         tile_reset <= 1'b0;
      end else begin
         sys_reset  <= sys_busy;
         tile_reset <= tile_busy || sys_busy;
      end
   end

   // answer one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         resp <= '0;
      end else begin
         resp.valid <= take && !quiet
                       && (!req.write || req.want_resp);
         resp.ack   <= req.write ? !wr_bad : mapped;
         resp.data  <= (req.write || !mapped) ? 32'h0 : rd_word;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_id_fields: assert property (
      take && !req.write && is_id |=> resp.valid
      && resp.data[31:24] == CHIP_ID && resp.data[15:8] == REV_ID
      && resp.data[7:0] == VER_ID)
      else $error("identification fields wrong");
   a_id_strap: assert property (
      take && !req.write && is_id |=> resp.data[ID_OSC_BIT] == osc_boot)
      else $error("oscillator strap bit wrong");
   a_lock_hold: assert property (
      cfg_lock && wr && (is_ncfg || is_link) && !sys_go
      |=> $stable(link_ctrl) && $stable(one_byte_hdr) && cfg_lock)
      else $error("write passed through lock");
   a_hdr_write: assert property (
      wr_ncfg && !sys_go |=> one_byte_hdr == $past(req.data[0]))
      else $error("header mode not updated");
   a_nid_upper: assert property (
      take && !req.write && is_nid |=> resp.data[31:16] == 16'h0000)
      else $error("node id upper half not zero");
   a_pin_reset: assert property (
      !pin_low_n |=> sys_busy ##1 sys_reset && tile_reset)
      else $error("reset pin did not reset system");
   a_tile_only: assert property (
      (sleep_enter || clk_switch) && !sys_go && !sys_busy
      |=> tile_busy ##1 tile_reset && !sys_reset)
      else $error("tile reset source misbehaved");
   a_rst_quiet: assert property (
      take && req.write && is_rmc && (req.data[1:0] != 2'b00)
      |=> !resp.valid)
      else $error("reset write got a response");
   a_self_clear: assert property (
      take && !req.write && is_rmc |=> resp.data[1:0] == 2'b00)
      else $error("reset bits not self clearing");
   a_mode_tri: assert property (
      wr_rmc && !sys_go |=> mode_pin_oe == {2{~$past(req.data[24])}}
      && mode_pin_o == $past(req.data[17:16]))
      else $error("mode pin control wrong");
   a_sw_sys: assert property (
      sw_sys |=> sys_busy ##1 sys_reset)
      else $error("software system reset not started");
endmodule

// ---- shared/anode_pkg.sv ----
// constants and carrier types of the analogue node configuration bank
// assumes one 200 MHz reference clock and a synchronous active-high reset
// Overview of operation
// - identification reads chip id, analogue revision and version bytes.
// - identification bit 16 shows the oscillator-select strap at power-up.
// - lock bit 31 of node configuration blocks writes there and to link.
// - node configuration bit 0 picks 1-byte headers, else 3-byte; reset 0.
// - node identifier holds a 16-bit writable value, upper half zero.
// - system reset covers everything, tile reset only the processor tiles.
// - reset pin low, supply brown-out or watchdog expiry start system reset.
// - sleep sequence or clock source change start only a tile reset.
// - system reset length is a counter of 524,288 oscillator cycles.
// - writing 1 to reset control bit 1 starts a tile reset, self clearing.
// - writing 1 to reset control bit 0 starts a system reset, self clearing.
// - a write that sets either reset bit gets no response packet.
// - reset control bits 17:16 drive mode pins, bit 24 tristates them.
package anode_pkg;
   // register numbers
   localparam logic [7:0] REG_DEVICE_ID  = 8'h00;
   localparam logic [7:0] REG_NODE_CFG   = 8'h04;
   localparam logic [7:0] REG_NODE_ID    = 8'h05;
   localparam logic [7:0] REG_RESET_MODE = 8'h50;
   localparam logic [7:0] REG_CLK_FREQ   = 8'h51;
   localparam logic [7:0] REG_LINK_CTRL  = 8'h80;
   localparam logic [7:0] REG_WDOG_TIME  = 8'hd6;
   localparam logic [7:0] REG_WDOG_OFF   = 8'hd7;
   // field positions
   localparam int ID_CHIP_LSB   = 24;
   localparam int ID_OSC_BIT    = 16;
   localparam int ID_REV_LSB    = 8;
   localparam int NCFG_LOCK_BIT = 31;
   localparam int NCFG_HDR_BIT  = 0;
   localparam int RMC_TRI_BIT   = 24;
   localparam int RMC_MODE_LSB  = 16;
   localparam int RMC_TILE_BIT  = 1;
   localparam int RMC_SYS_BIT   = 0;
   // values after reset and legal ranges
   localparam logic [6:0]  CLKF_RESET  = 7'h19;
   localparam logic [6:0]  CLKF_MIN    = 7'h05;
   localparam logic [6:0]  CLKF_MAX    = 7'h64;
   localparam logic [31:0] LINK_RESET  = 32'h0000_0801;
   localparam logic [31:0] LINK_RW     = 32'hc03f_ffff;
   localparam logic [15:0] WDOG_RESET  = 16'h03e8;
   localparam logic [31:0] WDOG_OFF_RESET = 32'h0d15_ab1e;
   localparam logic [1:0]  MODE_RESET  = 2'h0;
   // cycle counts
   localparam int SYS_RST_COUNT  = 524288;
   localparam int TILE_RST_COUNT = 16;
   localparam logic [2:0] OSC_SETTLE = 3'h4;
   // configuration request and answer
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        want_resp;
      logic [7:0]  num;
      logic [31:0] data;
   } cfg_req_t;
   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [31:0] data;
   } cfg_resp_t;
endpackage

// ---- verilog/pin_sync3.sv ----
// three-stage pin synchroniser with agreement filter
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync3 #(
   parameter logic IDLE = 1'b0
) (
   input  wire logic ref_clk, // reference clock
   input  wire logic sys_rst, // synchronous reset
   input  wire logic pin,     // raw pin level
   output logic      level    // filtered level
);
   logic s1;
   logic s2;
   logic s3;

   // a change counts once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s1    <= IDLE;
         s2    <= IDLE;
         s3    <= IDLE;
         level <= IDLE;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level <= s3;
      end
   end
endmodule

// ---- verilog/reset_span_timer.sv ----
// fixed-length reset span counter, restarted by every start pulse
// assumes start is a same-clock pulse or level
`timescale 1ns/1ps
module reset_span_timer #(
   parameter int CYCLES = 16
) (
   input  wire logic ref_clk, // reference clock
   input  wire logic sys_rst, // synchronous reset
   input  wire logic start,   // begin or restart the span
   output logic      busy     // high for CYCLES cycles after start
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] remain;

   // count down the span, release only when it completes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy   <= 1'b0;
         remain <= '0;
      end else if (start) begin
         busy   <= 1'b1;
         remain <= W'(CYCLES - 1);
      end else if (busy && remain == '0) begin
         busy <= 1'b0;
      end else if (busy) begin
         remain <= remain - 1'b1;
      end
   end

   a_span_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
      start |=> busy && remain == W'(CYCLES - 1))
      else $error("reset span did not load full count");
   a_span_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
      busy && !start && remain == '0 |=> !busy)
      else $error("reset span did not end at zero");
   a_span_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      busy && remain != '0 |=> busy)
      else $error("reset span ended early");
endmodule

// ---- dv/cfg_master.sv ----
// configuration master model: numbered read and write requests
// assumes the answer is registered on the same ref_clk edge that takes the request
`timescale 1ns/1ps
module cfg_master (
   input  wire logic                ref_clk, // reference clock
   input  wire anode_pkg::cfg_resp_t resp,   // answer from the bank
   output anode_pkg::cfg_req_t      req      // request to the bank
);
   import anode_pkg::*;
   initial req = '0;
   // one request held for one edge, answer sampled after that edge
   task automatic xfer(input logic wr, input logic w, input logic [7:0] n,
                       input logic [31:0] d, output logic got,
                       output logic ack, output logic [31:0] q);
      @(posedge ref_clk);
      #1 req = {1'b1, wr, w, n, d};
      @(posedge ref_clk);
      #1 got = resp.valid;
      ack = resp.ack;
      q = resp.data;
      // released lines show the inverse, never the stale value
      req = {1'b0, ~wr, ~w, ~n, ~d};
   endtask
endmodule

// ---- dv/analogue_node_config_reset_bench.sv ----
// self-checking bench of the analogue node configuration bank
// assumes short reset spans set by parameter, one 200 MHz clock
`timescale 1ns/1ps
module analogue_node_config_reset_bench;
   import anode_pkg::*;
   localparam int SYS_N = 20;
   localparam int TILE_N = 4;
   localparam logic [7:0] CHIP = 8'h3c; // arbitrary value
   localparam logic [7:0] REV = 8'h47;  // arbitrary value
   localparam logic [7:0] VER = 8'h81;  // arbitrary value
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        rst_pin_n = 1'b1;
   logic        brown_out = 1'b0;
   logic        oscillator_select_pin = 1'b1;
   logic        wdog_expire = 1'b0;
   logic        sleep_enter = 1'b0;
   logic        clk_switch = 1'b0;
   cfg_req_t    req;
   cfg_resp_t   resp;
   logic        sys_reset, tile_reset, one_byte_hdr, wdog_enabled;
   logic [15:0] node_id, wdog_timeout;
   logic [6:0]  clk_mhz;
   logic [31:0] link_ctrl, q;
   logic [1:0]  mode_pin_o, mode_pin_oe;
   logic        got, ack;
   int          num_errors = 0;
   int          num_checks = 0;
   int          len;

   always #2.5 ref_clk = ~ref_clk;

   analogue_node_cfg #(.CHIP_ID(CHIP), .REV_ID(REV), .VER_ID(VER),
      .SYS_RST_CYCLES(SYS_N), .TILE_RST_CYCLES(TILE_N)) analogue_node_cfg_i (
      .ref_clk, .sys_rst, .req, .resp, .rst_pin_n, .brown_out,
      .oscillator_select_pin, .wdog_expire, .sleep_enter, .clk_switch,
      .sys_reset, .tile_reset, .one_byte_hdr, .node_id, .clk_mhz,
      .link_ctrl, .wdog_timeout, .wdog_enabled, .mode_pin_o, .mode_pin_oe);
   cfg_master cfg_master_i (.ref_clk, .resp, .req);

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   // verdict and end of run
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // write, then judge whether and how it was answered
   task automatic wr(input logic [7:0] n, input logic [31:0] d,
                     input logic w, input logic eg, input logic ea);
      cfg_master_i.xfer(1'b1, w, n, d, got, ack, q);
      chk(got, eg);
      if (eg) chk(ack, ea);
   endtask
   // read, then judge answer and word
   task automatic rd(input logic [7:0] n, input logic eg, input logic ea,
                     input logic [31:0] ed);
      cfg_master_i.xfer(1'b0, 1'b0, n, 32'h0, got, ack, q);
      chk(got, eg);
      if (eg) chk({ack, q}, {ea, ed});
   endtask
   // wait for a reset output to rise, count its high cycles
   task automatic span(input logic sys, output int n);
      int i;
      n = 0;
      for (i = 0; i < 40 && (sys ? sys_reset : tile_reset) !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 40) begin
         num_errors++;
         test_done;
      end
      while ((sys ? sys_reset : tile_reset) === 1'b1 && n < 200) begin
         n++;
         @(posedge ref_clk);
         #1;
      end
      if (n == 200) begin
         num_errors++;
         test_done;
      end
   endtask

   task automatic t_reset_values;
      rd(REG_DEVICE_ID, 1, 1, {CHIP, 7'h0, 1'b1, REV, VER});
      wr(REG_DEVICE_ID, 32'h0, 1, 1, 0);
      rd(8'h33, 1, 0, 32'h0);
      chk({one_byte_hdr, node_id}, 17'h0);
      chk({clk_mhz, wdog_timeout, wdog_enabled}, {7'd25, 16'h03e8, 1'b0});
      chk({sys_reset, tile_reset, mode_pin_oe}, 4'h0);
      $display("reset values done");
   endtask
   task automatic t_node_id;
      wr(REG_NODE_ID, 32'hffff_1234, 1, 1, 1);
      rd(REG_NODE_ID, 1, 1, 32'h0000_1234);
      wr(REG_NODE_ID, 32'h0000_abcd, 0, 0, 0);
      chk(node_id, 16'habcd);
      $display("node identifier done");
   endtask
   task automatic t_lock;
      wr(REG_NODE_CFG, 32'h1, 1, 1, 1);
      chk(one_byte_hdr, 1'b1);
      wr(REG_LINK_CTRL, 32'hc000_0123, 1, 1, 1);
      chk(link_ctrl, 32'hc000_0123);
      wr(REG_NODE_CFG, 32'h8000_0001, 1, 1, 1);
      wr(REG_NODE_CFG, 32'h0, 1, 1, 1);
      wr(REG_LINK_CTRL, 32'h0000_0555, 1, 1, 1);
      chk({one_byte_hdr, link_ctrl}, {1'b1, 32'hc000_0123});
      $display("lock done");
   endtask
   task automatic t_mode_pins;
      wr(REG_RESET_MODE, 32'h0002_0000, 1, 1, 1);
      chk({mode_pin_oe, mode_pin_o}, 4'he);
      rd(REG_RESET_MODE, 1, 1, 32'h0002_0000);
      wr(REG_RESET_MODE, 32'h0103_0000, 1, 1, 1);
      chk({mode_pin_oe, mode_pin_o}, 4'h3);
      $display("mode pins done");
   endtask
   task automatic t_tile_reset;
      wr(REG_RESET_MODE, 32'h0103_0002, 1, 0, 0);
      span(1'b0, len);
      chk(len, TILE_N);
      rd(REG_RESET_MODE, 1, 1, 32'h0103_0000);
      // sleep entry, then clock switch
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         #1 {sleep_enter, clk_switch} = k ? 2'b01 : 2'b10;
         @(posedge ref_clk);
         #1 {sleep_enter, clk_switch} = 2'b00;
         span(1'b0, len);
         chk({len, sys_reset}, {TILE_N, 1'b0});
      end
      $display("tile reset done");
   endtask
   task automatic t_sys_reset;
      wr(REG_NODE_ID, 32'h0000_5555, 1, 1, 1);
      wr(REG_RESET_MODE, 32'h0000_0001, 1, 0, 0);
      span(1'b1, len);
      chk(len, SYS_N);
      chk({node_id, one_byte_hdr, mode_pin_oe}, 19'h0);
      chk(link_ctrl, LINK_RESET);
      wr(REG_NODE_CFG, 32'h1, 1, 1, 1);
      chk(one_byte_hdr, 1'b1);
      $display("software system reset done");
   endtask
   task automatic t_hw_resets;
      // watchdog, brown-out, reset pin
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         #1 {wdog_expire, brown_out, rst_pin_n} =
            (k == 0) ? 3'b101 : ((k == 1) ? 3'b011 : 3'b000);
         if (k == 0) begin
            repeat (3) @(posedge ref_clk);
            #1 chk(tile_reset, 1'b1);
            rd(REG_NODE_ID, 0, 0, 32'h0);
         end else
            repeat (6) @(posedge ref_clk);
         #1 {wdog_expire, brown_out, rst_pin_n} = 3'b001;
         span(1'b1, len);
         chk(one_byte_hdr, 1'b0);
      end
      $display("hardware system resets done");
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      repeat (8) @(posedge ref_clk);
      t_reset_values;
      t_node_id;
      t_lock;
      t_mode_pins;
      t_tile_reset;
      t_sys_reset;
      t_hw_resets;
      test_done;
   end
endmodule
